// [sim/spcr_pads.sv]
`timescale 1ns/1ps

// ****************************************
// Key matrix and indicator pad model
// ****************************************
module spcr_pads (
	input  wire logic       clk_in,
	input  wire logic       press_a_in,
	input  wire logic       press_b_in,
	input  wire logic       press_c_in,
	input  wire logic [3:0] press_key_in,
	input  wire logic       a_pd_in,
	input  wire logic       b_out_in,
	input  wire logic       b_oe_in,
	input  wire logic       b_pd_in,
	input  wire logic       c_pd_in,
	input  wire logic       key_pd_in,
	output logic            a_out,
	output logic            b_out,
	output logic            c_out,
	output logic [3:0]      key_out
);
	logic flt_ff = 1'b0;

	// Floating pads wander so a stale level never passes as real
	always @(posedge clk_in)
		flt_ff <= ~flt_ff;

	// Driven pin B wins, else pressed key, else pull-down, else floating
	assign a_out = press_a_in | (~a_pd_in & flt_ff);
	assign b_out = b_oe_in ? b_out_in : (press_b_in | (~b_pd_in & ~flt_ff));
	assign c_out = press_c_in | (~c_pd_in & flt_ff);
	assign key_out = press_key_in | ({4{~key_pd_in}} & {4{flt_ff}});
endmodule // spcr_pads

// [sim/tb_special_port_control_regs.sv]
`timescale 1ns/1ps
`include "spcr_defs.svh"

module tb_special_port_control_regs;
	logic clk, rst_n, psel, penable, pwrite, tmr, low_v;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err;
	logic pa, pb, pc, a_en, a_pd, b_o, b_oe, b_pd, c_pd, c_wk, ks_m, ks_pd, k_pd, flag;
	logic sa, sb, sc;
	logic [3:0] pk, keys, ptr;
	int errors = 0;
	int num_checks = 0;

	spcr_top i_spcr_top (.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.SENSE_A_IN(sa), .SENSE_B_IN(sb), .SENSE_C_IN(sc), .KEY_INPUT_IN(keys),
		.INDICATOR_TIMER_ACTIVE_IN(tmr), .SUPPLY_BELOW_KEEP_IN(low_v),
		.SENSE_A_INPUT_EN_OUT(a_en), .SENSE_A_PULLDOWN_OUT(a_pd), .SENSE_B_OUT(b_o),
		.SENSE_B_OE_OUT(b_oe), .SENSE_B_PULLDOWN_OUT(b_pd), .SENSE_C_PULLDOWN_OUT(c_pd),
		.SENSE_C_WAKE_EN_OUT(c_wk), .KEY_SCAN_OUTPUT_MODE_OUT(ks_m),
		.KEY_SCAN_PULLDOWN_OUT(ks_pd), .KEY_INPUT_PULLDOWN_OUT(k_pd),
		.ROM_POINTER_HIGH_OUT(ptr), .RAM_KEEP_FLAG_OUT(flag));

	spcr_pads i_spcr_pads (.clk_in(clk), .press_a_in(pa), .press_b_in(pb), .press_c_in(pc),
		.press_key_in(pk), .a_pd_in(a_pd), .b_out_in(b_o), .b_oe_in(b_oe), .b_pd_in(b_pd),
		.c_pd_in(c_pd), .key_pd_in(k_pd), .a_out(sa), .b_out(sb), .c_out(sc), .key_out(keys));

	// ****************************************
	// Clock, checks and bus tasks
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One APB transfer; waits on pready, one idle edge after for a clean restart
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Write, then one edge for the pin outputs to follow
	task automatic wr_pins(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(posedge clk);
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_reset();
		apb(1'b0, `SPCR_OFS_CTRL1, 32'h0);
		chk(rd, 32'h26);
		apb(1'b0, `SPCR_OFS_CTRL0, 32'h0);
		chk(rd, 32'h00);
		chk({a_en, a_pd}, 2'b00);
		chk({b_oe, b_o, b_pd}, 3'b110);
		chk({c_pd, c_wk}, 2'b00);
		apb(1'b0, `SPCR_OFS_INPUT, 32'h0);
		chk(rd[2], 1'b1);
	endtask

	// Bit 7..6 ignored, each mode bit reaches its pin control
	task automatic s_modes();
		wr_pins(`SPCR_OFS_CTRL1, 32'hFF);
		apb(1'b0, `SPCR_OFS_CTRL1, 32'h0);
		chk(rd, 32'h3F);
		chk({a_en, a_pd}, 2'b11);
		chk({b_oe, b_pd}, 2'b10);
		chk({c_pd, c_wk}, 2'b11);
		chk({ks_m, k_pd, ks_pd}, 3'b110);
		wr_pins(`SPCR_OFS_CTRL1, 32'h10);
		chk({a_en, a_pd}, 2'b00);
		chk(ks_pd, 1'b1);
		chk({b_oe, b_pd}, 2'b01);
		chk({ks_m, k_pd, c_pd}, 3'b000);
	endtask

	task automatic s_inputs();
		pc <= 1'b1;
		pk <= 4'hA;
		wr_pins(`SPCR_OFS_CTRL1, 32'h31);
		apb(1'b0, `SPCR_OFS_INPUT, 32'h0);
		chk(rd, 32'hA3);
		wr_pins(`SPCR_OFS_CTRL1, 32'h39);
		apb(1'b0, `SPCR_OFS_INPUT, 32'h0);
		chk(rd[1], 1'b1);
		tmr <= 1'b1;
		pb <= 1'b1;
		wr_pins(`SPCR_OFS_CTRL1, 32'h35);
		apb(1'b0, `SPCR_OFS_INPUT, 32'h0);
		chk({rd[3], b_pd}, 2'b00);
		tmr <= 1'b0;
		repeat (2) @(posedge clk);
		apb(1'b0, `SPCR_OFS_INPUT, 32'h0);
		chk(rd[3], 1'b1);
	endtask

	// Flag survives reset, then cleared by low supply
	task automatic s_flag();
		wr_pins(`SPCR_OFS_CTRL0, 32'h08);
		chk(flag, 1'b1);
		do_reset();
		apb(1'b0, `SPCR_OFS_CTRL0, 32'h0);
		chk(rd, 32'h08);
		low_v <= 1'b1;
		repeat (2) @(posedge clk);
		low_v <= 1'b0;
		@(posedge clk);
		chk(flag, 1'b0);
	endtask

	task automatic s_regs();
		wr_pins(`SPCR_OFS_CTRL0, 32'h5F);
		apb(1'b0, `SPCR_OFS_CTRL0, 32'h0);
		chk(rd, 32'h58);
		chk(ptr, 4'h5);
		apb(1'b1, `SPCR_OFS_INPUT, 32'hFF);
		chk(err, 1'b0);
		apb(1'b0, `SPCR_OFS_CTRL1, 32'h0);
		chk(rd, 32'h26);
		chk(ptr, 4'h5);
		apb(1'b1, 8'h0C, 32'hFF);
		chk(err, 1'b1);
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		{psel, penable, pwrite, tmr, pa, pb, pc} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pk = 4'h0;
		low_v = 1'b1;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		low_v <= 1'b0;
		@(posedge clk);
		s_reset();
		s_modes();
		s_inputs();
		s_flag();
		s_regs();
		test_done();
	end

	// Whole run is about a hundred cycles; this is ample
	initial
	begin
		#200000;
		errors++;
		test_done();
	end
endmodule // tb_special_port_control_regs

// [verilog/spcr_defs.svh]
// Overview of operation
// R1: Port-mode bit 0 selects sense pin A: 0 off at high impedance, 1 readable input.
// R2: Sense pin A in off mode reads back as 1 regardless of pin level.
// R3: After reset sense pin A is off and its pin is high impedance.
// R4: Port-mode bit 4 enables pull-downs on pins A and B, input mode only.
// R5: Port-mode bit 2 sets pin B direction: 0 input, 1 indicator output.
// R6: Reading pin B returns the real pin level in both modes.
// R7: In output mode pin B drops its pull-down and shows the timer indicator.
// R8: After reset pin B is an output driving high.
// R9: Port-mode bit 3 enables pin C wake-up and its pull-down together.
// R10: Pin C level is readable whether wake-up is enabled or not.
// R11: After reset pin C is an input, wake-up off, no pull-down.
// R12: Pointer register bits 7..4 hold the upper ROM pointer bits; software keeps bit 7 zero.
// R13: Pointer register is 8 bits, resets to zero except the retention flag bit 3.
// R14: Hardware clears the retention flag whenever supply drops below the keep level.
// R15: Software writes 1 to the retention flag after initialising RAM.
// R16: Reset alone never clears the retention flag.
// R17: Port-mode register is 8 bits, resets to 0x26, bits 7 and 6 read 0.
// R18: Port-mode bit 1 sets key-scan port direction: 0 input, 1 output.
// R19: Port-mode bit 5 enables the group pull-down on the four key inputs.
// R20: Any pin in output or off mode has its pull-down disconnected.
// R21: Input port bit 1 is pin C, bit 2 pin A, bit 3 pin B, read only.
// R22: Writes to read-only or fixed-zero bits have no effect.
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SPCR_OFS_INPUT      8'h00
`define SPCR_OFS_CTRL0      8'h04
`define SPCR_OFS_CTRL1      8'h08

// ****************************************
// Field positions
// ****************************************
`define SPCR_IN_FIXED       0
`define SPCR_IN_SC          1
`define SPCR_IN_SA          2
`define SPCR_IN_SB          3
`define SPCR_IN_KEY_LO      4
`define SPCR_C0_FLAG        3
`define SPCR_C0_PTR_LO      4
`define SPCR_C1_SA_MODE     0
`define SPCR_C1_KSCAN_MODE  1
`define SPCR_C1_SB_MODE     2
`define SPCR_C1_SC_WAKE     3
`define SPCR_C1_SAB_PD      4
`define SPCR_C1_KIN_PD      5

// ****************************************
// Reset values and write masks
// ****************************************
`define SPCR_C1_RESET       8'h26
`define SPCR_C1_WMASK       8'h3F
`define SPCR_C0_PTR_RESET   4'h0

// ****************************************
// Timing: register answer wait states
// ****************************************
`define SPCR_APB_WAIT       0

`endif

// [verilog/spcr_pkg.sv]
package spcr_pkg;

	// Bus slave phase, one-hot
	typedef enum logic [1:0]
	{
		SPCR_IDLE   = 2'b01,
		SPCR_ANSWER = 2'b10
	} spcr_state_type;

endpackage

// [verilog/spcr_top.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_top #(
	parameter int ADDR_W = 8
)(
	input  wire logic              CLOCK_IN,
	input  wire logic              RST_N_IN,
	input  wire logic              PSEL_IN,
	input  wire logic              PENABLE_IN,
	input  wire logic              PWRITE_IN,
	input  wire logic [ADDR_W-1:0] PADDR_IN,
	input  wire logic [31:0]       PWDATA_IN,
	output logic      [31:0]       PRDATA_OUT,
	output logic                   PREADY_OUT,
	output logic                   PSLVERR_OUT,
	input  wire logic              SENSE_A_IN,
	input  wire logic              SENSE_B_IN,
	input  wire logic              SENSE_C_IN,
	input  wire logic [3:0]        KEY_INPUT_IN,
	input  wire logic              INDICATOR_TIMER_ACTIVE_IN,
	input  wire logic              SUPPLY_BELOW_KEEP_IN,
	output logic                   SENSE_A_INPUT_EN_OUT,
	output logic                   SENSE_A_PULLDOWN_OUT,
	output logic                   SENSE_B_OUT,
	output logic                   SENSE_B_OE_OUT,
	output logic                   SENSE_B_PULLDOWN_OUT,
	output logic                   SENSE_C_PULLDOWN_OUT,
	output logic                   SENSE_C_WAKE_EN_OUT,
	output logic                   KEY_SCAN_OUTPUT_MODE_OUT,
	output logic                   KEY_SCAN_PULLDOWN_OUT,
	output logic                   KEY_INPUT_PULLDOWN_OUT,
	output logic      [3:0]        ROM_POINTER_HIGH_OUT,
	output logic                   RAM_KEEP_FLAG_OUT
);

	// ****************************************
	// Address decoding
	// ****************************************

	// Shared by read select and write strobes
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ADDR_W'(ofs));
	endfunction

	spcr_pkg::spcr_state_type state_ff;
	spcr_pkg::spcr_state_type nxt_state;
	logic        pready_ff;
	logic        nxt_pready;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pslverr_ff;
	logic        nxt_pslverr;
	logic [7:0]  ctrl1_ff;
	logic [7:0]  nxt_ctrl1;
	logic [3:0]  ptr_ff;
	logic [3:0]  nxt_ptr;
	logic        flag_ff;
	logic        sa_en_ff;
	logic        sa_pd_ff;
	logic        sb_out_ff;
	logic        sb_oe_ff;
	logic        sb_pd_ff;
	logic        sc_pd_ff;
	logic        sc_wake_ff;
	logic        kscan_mode_ff;
	logic        kscan_pd_ff;
	logic        kin_pd_ff;

	wire hit_input = reg_hit(PADDR_IN, `SPCR_OFS_INPUT);
	wire hit_ctrl0 = reg_hit(PADDR_IN, `SPCR_OFS_CTRL0);
	wire hit_ctrl1 = reg_hit(PADDR_IN, `SPCR_OFS_CTRL1);
	wire hit_any   = hit_input | hit_ctrl0 | hit_ctrl1;
	wire setup_ph  = PSEL_IN & ~PENABLE_IN;
	// Writes land only on the completing access edge
	wire wr_done   = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_ff;
	// R22 read-only input word takes no write strobe
	wire wr_ctrl0  = wr_done & hit_ctrl0;
	wire wr_ctrl1  = wr_done & hit_ctrl1;

	// ****************************************
	// Read words
	// ****************************************

	// R2 off mode reads as 1, blocks unknown floating level
	wire sa_read = ctrl1_ff[`SPCR_C1_SA_MODE] ? SENSE_A_IN : 1'b1;
	// R21 input port layout, R6 and R10 raw pin levels
	wire [31:0] input_word = {24'h000000, KEY_INPUT_IN, SENSE_B_IN, sa_read, SENSE_C_IN, 1'b1};
	// R13 low bits fixed zero
	wire [31:0] ctrl0_word = {24'h000000, ptr_ff, flag_ff, 3'h0};
	wire [31:0] ctrl1_word = {24'h000000, ctrl1_ff};
	wire [31:0] rd_word    = hit_input ? input_word :
				hit_ctrl0 ? ctrl0_word :
				hit_ctrl1 ? ctrl1_word : 32'h00000000;

	// ****************************************
	// Bus slave phase machine
	// ****************************************

	// Zero wait states: answer always in the first access cycle
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_pready  = 1'b0;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		unique case (state_ff)
			spcr_pkg::SPCR_IDLE:
			begin
				if (setup_ph)
				begin
					nxt_state   = spcr_pkg::SPCR_ANSWER;
					nxt_pready  = 1'b1;
					nxt_pslverr = ~hit_any;
					nxt_prdata  = PWRITE_IN ? 32'h00000000 : rd_word;
				end
			end
			spcr_pkg::SPCR_ANSWER:
			begin
				nxt_state = spcr_pkg::SPCR_IDLE;
			end
			default:
			begin
				nxt_state = spcr_pkg::SPCR_IDLE;
			end
		endcase
	end

	// Bus answer registers
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			state_ff   <= spcr_pkg::SPCR_IDLE;
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************

	// R17 bits 7..6 masked to zero, R22 fixed bits ignored
	assign nxt_ctrl1 = wr_ctrl1 ? (PWDATA_IN[7:0] & `SPCR_C1_WMASK) : ctrl1_ff;
	// R12 pointer high bits, stored as written
	assign nxt_ptr   = wr_ctrl0 ? PWDATA_IN[7:4] : ptr_ff;

	// R3 R8 R11 R13 R17 reset values
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ctrl1_ff <= `SPCR_C1_RESET;
			ptr_ff   <= `SPCR_C0_PTR_RESET;
		end
		else
		begin
			ctrl1_ff <= nxt_ctrl1;
			ptr_ff   <= nxt_ptr;
		end
	end

	// R16 retention flag kept out of reset on purpose
	// R14 undervoltage clear wins over a software set
	always_ff @(posedge CLOCK_IN)
	begin
		if (SUPPLY_BELOW_KEEP_IN)
			flag_ff <= 1'b0;
		else if (wr_ctrl0)
			flag_ff <= PWDATA_IN[`SPCR_C0_FLAG];
	end

	// ****************************************
	// Pin control outputs
	// ****************************************

	// R1 pin A input buffer enable
	wire nxt_sa_en = ctrl1_ff[`SPCR_C1_SA_MODE];
	// R4 R20 shared A/B pull-down only while in input mode
	wire nxt_sa_pd = ctrl1_ff[`SPCR_C1_SAB_PD] & ctrl1_ff[`SPCR_C1_SA_MODE];
	wire nxt_sb_pd = ctrl1_ff[`SPCR_C1_SAB_PD] & ~ctrl1_ff[`SPCR_C1_SB_MODE];
	// R5 pin B direction
	wire nxt_sb_oe = ctrl1_ff[`SPCR_C1_SB_MODE];
	// R7 indicator low while the timer runs, high when halted
	wire nxt_sb_out = ~INDICATOR_TIMER_ACTIVE_IN;
	// R9 wake and pull-down move together on pin C
	wire nxt_sc_on = ctrl1_ff[`SPCR_C1_SC_WAKE];
	// R18 key-scan direction, R20 its pull-down in input mode only
	wire nxt_kscan = ctrl1_ff[`SPCR_C1_KSCAN_MODE];
	// R19 key input group pull-down
	wire nxt_kin_pd = ctrl1_ff[`SPCR_C1_KIN_PD];

	// One cycle behind the control register and the timer input, glitch free at the pads
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sa_en_ff      <= 1'b0;
			sa_pd_ff      <= 1'b0;
			sb_out_ff     <= 1'b1;
			sb_oe_ff      <= 1'b1;
			sb_pd_ff      <= 1'b0;
			sc_pd_ff      <= 1'b0;
			sc_wake_ff    <= 1'b0;
			kscan_mode_ff <= 1'b1;
			kscan_pd_ff   <= 1'b0;
			kin_pd_ff     <= 1'b1;
		end
		else
		begin
			sa_en_ff      <= nxt_sa_en;
			sa_pd_ff      <= nxt_sa_pd;
			sb_out_ff     <= nxt_sb_out;
			sb_oe_ff      <= nxt_sb_oe;
			sb_pd_ff      <= nxt_sb_pd;
			sc_pd_ff      <= nxt_sc_on;
			sc_wake_ff    <= nxt_sc_on;
			kscan_mode_ff <= nxt_kscan;
			kscan_pd_ff   <= ~nxt_kscan;
			kin_pd_ff     <= nxt_kin_pd;
		end
	end

	// Port drive
	assign PRDATA_OUT               = prdata_ff;
	assign PREADY_OUT               = pready_ff;
	assign PSLVERR_OUT              = pslverr_ff;
	assign SENSE_A_INPUT_EN_OUT     = sa_en_ff;
	assign SENSE_A_PULLDOWN_OUT     = sa_pd_ff;
	assign SENSE_B_OUT              = sb_out_ff;
	assign SENSE_B_OE_OUT           = sb_oe_ff;
	assign SENSE_B_PULLDOWN_OUT     = sb_pd_ff;
	assign SENSE_C_PULLDOWN_OUT     = sc_pd_ff;
	assign SENSE_C_WAKE_EN_OUT      = sc_wake_ff;
	assign KEY_SCAN_OUTPUT_MODE_OUT = kscan_mode_ff;
	assign KEY_SCAN_PULLDOWN_OUT    = kscan_pd_ff;
	assign KEY_INPUT_PULLDOWN_OUT   = kin_pd_ff;
	assign ROM_POINTER_HIGH_OUT     = ptr_ff;
	assign RAM_KEEP_FLAG_OUT        = flag_ff;

	// ****************************************
	// Checks
	// ****************************************

	// R1 pin A enable follows bit 0
	property p_sa_mode;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl1 |-> ##2 (SENSE_A_INPUT_EN_OUT == $past(PWDATA_IN[0], 2));
	endproperty
	a_sa_mode: assert property (p_sa_mode) else $error("pin A mode wrong"); // R1

	// R2 off mode reads 1
	property p_sa_off_read;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(state_ff == spcr_pkg::SPCR_IDLE && setup_ph && !PWRITE_IN && hit_input
			&& !ctrl1_ff[0]) |=> PRDATA_OUT[2];
	endproperty
	a_sa_off_read: assert property (p_sa_off_read) else $error("pin A off read not 1"); // R2

	// R3 R8 R11 state right after reset release
	property p_reset_pins;
		@(posedge CLOCK_IN)
		$rose(RST_N_IN) |-> (!SENSE_A_INPUT_EN_OUT && SENSE_B_OE_OUT && SENSE_B_OUT
			&& !SENSE_C_PULLDOWN_OUT && !SENSE_C_WAKE_EN_OUT);
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("pin reset state wrong"); // R3

	// R4 R20 pull-down on A/B only in input mode
	property p_sab_pd;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		##1 ((SENSE_A_PULLDOWN_OUT == $past(ctrl1_ff[4] & ctrl1_ff[0]))
			&& (SENSE_B_PULLDOWN_OUT == $past(ctrl1_ff[4] & ~ctrl1_ff[2])));
	endproperty
	a_sab_pd: assert property (p_sab_pd) else $error("A/B pull-down wrong"); // R4

	// R5 R7 pin B drive and indicator level
	property p_sb_drive;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl1 |-> ##2 ((SENSE_B_OE_OUT == $past(PWDATA_IN[2], 2))
			&& (SENSE_B_OUT == !$past(INDICATOR_TIMER_ACTIVE_IN)));
	endproperty
	a_sb_drive: assert property (p_sb_drive) else $error("pin B drive wrong"); // R5

	// R6 R10 R21 raw pin levels in input word
	property p_input_read;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(state_ff == spcr_pkg::SPCR_IDLE && setup_ph && !PWRITE_IN && hit_input)
			|=> (PRDATA_OUT[3] == $past(SENSE_B_IN) && PRDATA_OUT[1] == $past(SENSE_C_IN)
			&& PRDATA_OUT[0] && PREADY_OUT);
	endproperty
	a_input_read: assert property (p_input_read) else $error("input word wrong"); // R6

	// R9 wake and pull-down on C together
	property p_sc_wake;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		##1 ((SENSE_C_WAKE_EN_OUT == SENSE_C_PULLDOWN_OUT)
			&& (SENSE_C_WAKE_EN_OUT == $past(ctrl1_ff[3])));
	endproperty
	a_sc_wake: assert property (p_sc_wake) else $error("pin C wake wrong"); // R9

	// R12 pointer reaches its output
	property p_pointer;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl0 |=> (ROM_POINTER_HIGH_OUT == $past(PWDATA_IN[7:4]));
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer not stored"); // R12

	// R14 undervoltage clears the flag
	property p_flag_clear;
		@(posedge CLOCK_IN)
		SUPPLY_BELOW_KEEP_IN |=> !RAM_KEEP_FLAG_OUT;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("retention flag not cleared"); // R14

	// R16 reset leaves the flag alone
	property p_flag_hold;
		@(posedge CLOCK_IN)
		(!RST_N_IN && !SUPPLY_BELOW_KEEP_IN) |=> (RAM_KEEP_FLAG_OUT == $past(RAM_KEEP_FLAG_OUT));
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("reset changed retention flag"); // R16

	// R13 flag takes bit 3 of a write while the supply is good
	property p_flag_write;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(wr_ctrl0 && !SUPPLY_BELOW_KEEP_IN) |=> (RAM_KEEP_FLAG_OUT == $past(PWDATA_IN[3]));
	endproperty
	a_flag_write: assert property (p_flag_write) else $error("retention flag write wrong"); // R13

	// R17 port-mode write drops the two top bits
	property p_ctrl1_write;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ctrl1 |=> (ctrl1_ff == {2'b00, $past(PWDATA_IN[5:0])});
	endproperty
	a_ctrl1_write: assert property (p_ctrl1_write) else $error("port-mode write wrong"); // R17

	// R20 pin A off or pin B driving never has a pull-down
	property p_pd_off;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(SENSE_A_INPUT_EN_OUT || !SENSE_A_PULLDOWN_OUT)
			&& (!SENSE_B_OE_OUT || !SENSE_B_PULLDOWN_OUT);
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("pull-down left on"); // R20

	// R22 unmapped address answers an error with zero data
	property p_unmapped;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(state_ff == spcr_pkg::SPCR_IDLE && setup_ph && !hit_any)
			|=> (PSLVERR_OUT && PREADY_OUT && (PRDATA_OUT == 32'h00000000));
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped answer wrong"); // R22

	// R17 R22 fixed-zero bits stay zero
	property p_fixed_zero;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(ctrl1_ff[7:6] == 2'b00) && (!(PREADY_OUT && hit_ctrl0) || (PRDATA_OUT[2:0] == 3'h0));
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bits not zero"); // R17

	// R18 R19 R20 key port controls
	property p_key_ctrl;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		##1 ((KEY_SCAN_OUTPUT_MODE_OUT == $past(ctrl1_ff[1]))
			&& (KEY_SCAN_PULLDOWN_OUT == !KEY_SCAN_OUTPUT_MODE_OUT)
			&& (KEY_INPUT_PULLDOWN_OUT == $past(ctrl1_ff[5])));
	endproperty
	a_key_ctrl: assert property (p_key_ctrl) else $error("key port control wrong"); // R18

	// R22 write to input word changes neither the port-mode register nor the pointer bits
	property p_ro_write;
		@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		(wr_done && hit_input) |=> $stable(ctrl1_ff) && $stable(ptr_ff);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write had effect"); // R22

endmodule // spcr_top
